/* alert_pkg.sv */
// constants and register map of the alert limit and enable bank
// Behaviour
// - charger disable with its enable set pulls alert low and sets suspended status.
// - device answers alert response address and releases the alert line in the same cycle.
// - every register is sixteen bits wide.
// - bits active high; thresholds signed, everything else unsigned.
// - twelve read-write signed thresholds at 0x01 through 0x0c.
// - 0x0b is the cold-battery limit, 0x0c the hot-battery limit.
// - limit enables: bit 15 valid, 14 reserved, 13/12 charge-count low/high.
// - bits 11..5 enable voltage low/high and input-current high alerts.
// - bits 4..0 enable charge-current, die, resistance, cold and hot alerts.
// - enabled limit alerts that occur latch in status register 0x36.
// - charger-state enables at 0x0e, bits 10..6 for the charging phases.
// - enabled charger-state alerts that occur latch in status register 0x37.
package alert_pkg;
	localparam int REG_W = 16;
	localparam int ADDR_W = 8;
	localparam int LIMIT_N = 12;
	localparam logic [ADDR_W-1:0] ADDR_LIMIT_FIRST = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_LIMIT_LAST = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_LIMIT_EN = 8'h0d;
	localparam logic [ADDR_W-1:0] ADDR_STATE_EN = 8'h0e;
	localparam logic [ADDR_W-1:0] ADDR_LIMIT_STAT = 8'h36;
	localparam logic [ADDR_W-1:0] ADDR_STATE_STAT = 8'h37;
	localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
	// limit indices, in register order
	localparam int LIM_VBAT_LO = 0;
	localparam int LIM_VBAT_HI = 1;
	localparam int LIM_VIN_LO = 2;
	localparam int LIM_VIN_HI = 3;
	localparam int LIM_VSYS_LO = 4;
	localparam int LIM_VSYS_HI = 5;
	localparam int LIM_IIN_HI = 6;
	localparam int LIM_IBAT_LO = 7;
	localparam int LIM_DIE_HI = 8;
	localparam int LIM_BSR_HI = 9;
	localparam int LIM_COLD = 10;
	localparam int LIM_HOT = 11;
	// limit enable bits
	localparam int EN_MEAS_VALID = 15;
	localparam int EN_RESERVED = 14;
	localparam int EN_QCOUNT_LO = 13;
	localparam int EN_QCOUNT_HI = 12;
	localparam int EN_VBAT_LO = 11;
	localparam int EN_VBAT_HI = 10;
	localparam int EN_VIN_LO = 9;
	localparam int EN_VIN_HI = 8;
	localparam int EN_VSYS_LO = 7;
	localparam int EN_VSYS_HI = 6;
	localparam int EN_IIN_HI = 5;
	localparam int EN_IBAT_LO = 4;
	localparam int EN_DIE_HI = 3;
	localparam int EN_BSR_HI = 2;
	localparam int EN_COLD = 1;
	localparam int EN_HOT = 0;
	// charger-state enable bits
	localparam int ST_EQUALIZE = 10;
	localparam int ST_ABSORB = 9;
	localparam int ST_SUSPENDED = 8;
	localparam int ST_PRECHARGE = 7;
	localparam int ST_CONSTANT = 6;
	localparam logic [REG_W-1:0] LIMIT_EN_MASK = 16'hbfff;
	localparam logic [REG_W-1:0] STATE_EN_MASK = 16'h07c0;
	// arbitrary response address value, not from any real part
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h68;
	typedef enum logic [1:0] {
		ALERT_IDLE = 2'b00,
		ALERT_PEND = 2'b01,
		ALERT_DONE = 2'b10
	} alertState_t;
endpackage : alert_pkg

/* limit_compare.sv */
// signed threshold comparator for one limit
`timescale 1ns/10ps
module limit_compare
	import alert_pkg::*;
#(
	parameter bit IS_HIGH = 1'b0
) (
	// operands
	input  wire logic [REG_W-1:0] measure,
	input  wire logic [REG_W-1:0] limit,
	// result
	output logic                  event_
);
	always_comb begin
		if (IS_HIGH) begin
			event_ = $signed(measure) > $signed(limit);
		end else begin
			event_ = $signed(measure) < $signed(limit);
		end
	end
endmodule : limit_compare

/* sticky_bit.sv */
// one sticky status bit: set beats software clear
`timescale 1ns/10ps
module sticky_bit (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// control
	input  wire logic set,
	input  wire logic clear,
	// state
	output logic      flag
);
	logic flag_d;
	logic flag_q;
	always_comb begin
		flag_d = flag_q;
		if (clear) begin
			flag_d = 1'b0;
		end
		if (set) begin
			flag_d = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end
	assign flag = flag_q;
endmodule : sticky_bit

/* alert_limit_enable_bank.sv */
// alert thresholds, enables, latched status and the active-low alert line
`timescale 1ns/10ps
module alert_limit_enable_bank
	import alert_pkg::*;
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// register port from the serial interface
	input  wire logic                   regWrite,
	input  wire logic                   regRead,
	input  wire logic [ADDR_W-1:0]      regAddr,
	input  wire logic [REG_W-1:0]       regWdata,
	output logic      [REG_W-1:0]       regRdata,
	output logic                        regRvalid,
	// alert response request from the serial interface
	input  wire logic                   araRequest,
	output logic                        araAck,
	output logic      [6:0]             araAddr,
	// measurements, signed, same format as thresholds
	input  wire logic [LIMIT_N*REG_W-1:0] measures,
	input  wire logic                   measValid,
	// charge-count events from the counter
	input  wire logic                   qcountLow,
	input  wire logic                   qcountHigh,
	// charger phase levels
	input  wire logic                   equalizeActive,
	input  wire logic                   absorbActive,
	input  wire logic                   chargerSuspended,
	input  wire logic                   prechargeActive,
	input  wire logic                   constantPhase,
	// alert line, open drain
	output logic                        alertOut,
	output logic                        alertOe
);
	logic [REG_W-1:0]  limitReg_q [LIMIT_N];
	logic [REG_W-1:0]  limitReg_d [LIMIT_N];
	logic [REG_W-1:0]  limitEn_q;
	logic [REG_W-1:0]  limitEn_d;
	logic [REG_W-1:0]  stateEn_q;
	logic [REG_W-1:0]  stateEn_d;
	logic [LIMIT_N-1:0] cmpHit;
	logic [REG_W-1:0]  limitEvent;
	logic [REG_W-1:0]  stateEvent;
	logic [REG_W-1:0]  stateLevel_q;
	logic [REG_W-1:0]  stateLevel_d;
	logic [REG_W-1:0]  limitStat;
	logic [REG_W-1:0]  stateStat;
	logic [REG_W-1:0]  limitClr;
	logic [REG_W-1:0]  stateClr;
	logic [REG_W-1:0]  rdata_d;
	logic [REG_W-1:0]  rdata_q;
	logic              rvalid_q;
	alertState_t       alertSt_q;
	alertState_t       alertSt_d;
	logic              alertOe_q;
	logic              alertOe_d;
	logic              ack_q;
	logic              ack_d;
	logic              anyNew;
	logic [6:0]        araAddr_q;
	logic              alertOut_q;

	// comparators, one per threshold
	for (genvar i = 0; i < LIMIT_N; i++) begin : gCmp
		localparam bit HIGH = (i == LIM_VBAT_HI) || (i == LIM_VIN_HI) ||
			(i == LIM_VSYS_HI) || (i == LIM_IIN_HI) || (i == LIM_DIE_HI) ||
			(i == LIM_BSR_HI) || (i == LIM_COLD);
		limit_compare #(
			.IS_HIGH (HIGH)
		) uCmp (
			.measure (measures[i*REG_W +: REG_W]),
			.limit   (limitReg_q[i]),
			.event_  (cmpHit[i])
		);
	end

	// register writes
	always_comb begin
		for (int i = 0; i < LIMIT_N; i++) begin
			limitReg_d[i] = limitReg_q[i];
		end
		limitEn_d = limitEn_q;
		stateEn_d = stateEn_q;
		if (regWrite) begin
			for (int i = 0; i < LIMIT_N; i++) begin
				if (regAddr == ADDR_LIMIT_FIRST + ADDR_W'(i)) begin
					limitReg_d[i] = regWdata;
				end
			end
			if (regAddr == ADDR_LIMIT_EN) begin
				limitEn_d = regWdata & LIMIT_EN_MASK;
			end
			if (regAddr == ADDR_STATE_EN) begin
				stateEn_d = regWdata & STATE_EN_MASK;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < LIMIT_N; i++) begin
				limitReg_q[i] <= REG_RESET;
			end
			limitEn_q <= REG_RESET;
			stateEn_q <= REG_RESET;
		end else begin
			for (int i = 0; i < LIMIT_N; i++) begin
				limitReg_q[i] <= limitReg_d[i];
			end
			limitEn_q <= limitEn_d;
			stateEn_q <= stateEn_d;
		end
	end

	// gate raw events with their enables
	always_comb begin
		limitEvent = '0;
		limitEvent[EN_MEAS_VALID] = measValid & limitEn_q[EN_MEAS_VALID];
		limitEvent[EN_QCOUNT_LO]  = qcountLow & limitEn_q[EN_QCOUNT_LO];
		limitEvent[EN_QCOUNT_HI]  = qcountHigh & limitEn_q[EN_QCOUNT_HI];
		limitEvent[EN_VBAT_LO]    = cmpHit[LIM_VBAT_LO] & limitEn_q[EN_VBAT_LO];
		limitEvent[EN_VBAT_HI]    = cmpHit[LIM_VBAT_HI] & limitEn_q[EN_VBAT_HI];
		limitEvent[EN_VIN_LO]     = cmpHit[LIM_VIN_LO] & limitEn_q[EN_VIN_LO];
		limitEvent[EN_VIN_HI]     = cmpHit[LIM_VIN_HI] & limitEn_q[EN_VIN_HI];
		limitEvent[EN_VSYS_LO]    = cmpHit[LIM_VSYS_LO] & limitEn_q[EN_VSYS_LO];
		limitEvent[EN_VSYS_HI]    = cmpHit[LIM_VSYS_HI] & limitEn_q[EN_VSYS_HI];
		limitEvent[EN_IIN_HI]     = cmpHit[LIM_IIN_HI] & limitEn_q[EN_IIN_HI];
		limitEvent[EN_IBAT_LO]    = cmpHit[LIM_IBAT_LO] & limitEn_q[EN_IBAT_LO];
		limitEvent[EN_DIE_HI]     = cmpHit[LIM_DIE_HI] & limitEn_q[EN_DIE_HI];
		limitEvent[EN_BSR_HI]     = cmpHit[LIM_BSR_HI] & limitEn_q[EN_BSR_HI];
		limitEvent[EN_COLD]       = cmpHit[LIM_COLD] & limitEn_q[EN_COLD];
		limitEvent[EN_HOT]        = cmpHit[LIM_HOT] & limitEn_q[EN_HOT];
	end

	// charger phases fire on entry into each phase
	always_comb begin
		stateLevel_d = '0;
		stateLevel_d[ST_EQUALIZE]  = equalizeActive;
		stateLevel_d[ST_ABSORB]    = absorbActive;
		stateLevel_d[ST_SUSPENDED] = chargerSuspended;
		stateLevel_d[ST_PRECHARGE] = prechargeActive;
		stateLevel_d[ST_CONSTANT]  = constantPhase;
		stateEvent = stateLevel_d & ~stateLevel_q & stateEn_q;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stateLevel_q <= REG_RESET;
		end else begin
			stateLevel_q <= stateLevel_d;
		end
	end

	// status clear by writing zero
	always_comb begin
		limitClr = '0;
		stateClr = '0;
		if (regWrite && regAddr == ADDR_LIMIT_STAT) begin
			limitClr = ~regWdata;
		end
		if (regWrite && regAddr == ADDR_STATE_STAT) begin
			stateClr = ~regWdata;
		end
	end
	for (genvar b = 0; b < REG_W; b++) begin : gStat
		sticky_bit uLim (
			.clk   (clk),
			.rst_n (rst_n),
			.set   (limitEvent[b]),
			.clear (limitClr[b]),
			.flag  (limitStat[b])
		);
		sticky_bit uSt (
			.clk   (clk),
			.rst_n (rst_n),
			.set   (stateEvent[b]),
			.clear (stateClr[b]),
			.flag  (stateStat[b])
		);
	end

	// read port, one cycle after the request
	always_comb begin
		rdata_d = REG_RESET;
		if (regAddr >= ADDR_LIMIT_FIRST && regAddr <= ADDR_LIMIT_LAST) begin
			rdata_d = limitReg_q[4'(regAddr - ADDR_LIMIT_FIRST)];
		end else if (regAddr == ADDR_LIMIT_EN) begin
			rdata_d = limitEn_q;
		end else if (regAddr == ADDR_STATE_EN) begin
			rdata_d = stateEn_q;
		end else if (regAddr == ADDR_LIMIT_STAT) begin
			rdata_d = limitStat;
		end else if (regAddr == ADDR_STATE_STAT) begin
			rdata_d = stateStat;
		end
		if (!regRead) begin
			rdata_d = rdata_q;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q  <= REG_RESET;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= regRead;
		end
	end

	// alert line: pulled low on a new event, released by the response
	assign anyNew = |limitEvent | |stateEvent;
	always_comb begin
		alertSt_d = alertSt_q;
		ack_d     = 1'b0;
		case (alertSt_q)
			ALERT_IDLE: begin
				if (anyNew) begin
					alertSt_d = ALERT_PEND;
				end
			end
			ALERT_PEND: begin
				if (araRequest) begin
					ack_d     = 1'b1;
					alertSt_d = ALERT_DONE;
				end
			end
			ALERT_DONE: begin
				alertSt_d = anyNew ? ALERT_PEND : ALERT_IDLE;
			end
			default: begin
				alertSt_d = ALERT_IDLE;
			end
		endcase
		alertOe_d = (alertSt_d == ALERT_PEND);
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			alertSt_q  <= ALERT_IDLE;
			alertOe_q  <= 1'b0;
			ack_q      <= 1'b0;
			araAddr_q  <= DEV_ADDR_DEFAULT;
			alertOut_q <= 1'b0;
		end else begin
			alertSt_q  <= alertSt_d;
			alertOe_q  <= alertOe_d;
			ack_q      <= ack_d;
			// own address and open-drain data are fixed, still taken from flops
			araAddr_q  <= DEV_ADDR_DEFAULT;
			alertOut_q <= 1'b0;
		end
	end

	assign regRdata  = rdata_q;
	assign regRvalid = rvalid_q;
	assign araAck    = ack_q;
	assign araAddr   = araAddr_q;
	assign alertOut  = alertOut_q;
	assign alertOe   = alertOe_q;
endmodule : alert_limit_enable_bank

/* alert_limit_enable_bank_monitor.sv */
// port assertions for the alert bank
`timescale 1ns/10ps
module alert_limit_enable_bank_monitor
	import alert_pkg::*;
(
	// clock and reset
	input wire logic              clk,
	input wire logic              rst_n,
	// register port
	input wire logic              regWrite,
	input wire logic              regRead,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [REG_W-1:0]  regWdata,
	input wire logic [REG_W-1:0]  regRdata,
	input wire logic              regRvalid,
	// alert
	input wire logic              araRequest,
	input wire logic              araAck,
	input wire logic [6:0]        araAddr,
	input wire logic              alertOe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	read_answer_a: assert property (regRead |=> regRvalid)
		else $error("read not answered");
	valid_cause_a: assert property (regRvalid |-> $past(regRead))
		else $error("read data without a read");
	unmapped_zero_a: assert property (regRead && regAddr == 8'h20 |=> regRdata == 16'h0000)
		else $error("unmapped read not zero");
	thresh_rw_a: assert property (regWrite && regAddr inside {[8'h01:8'h0c]} ##2 regRead
		&& regAddr == $past(regAddr, 2) |=> regRdata == $past(regWdata, 3))
		else $error("threshold readback differs");
	limit_rsvd_a: assert property (regRead && regAddr == 8'h0d |=> !regRdata[14])
		else $error("reserved enable bit read as one");
	state_mask_a: assert property (regRead && regAddr == 8'h0e |=> regRdata[15:11] == 5'h00
		&& regRdata[5:0] == 6'h00)
		else $error("unused state enable bits set");
	ara_release_a: assert property (araRequest && alertOe |=> araAck && !alertOe)
		else $error("alert not released on response");
	ack_addr_a: assert property (araAck |-> araAddr == DEV_ADDR_DEFAULT && $past(araRequest))
		else $error("bad alert claim");
	alert_holds_a: assert property (alertOe && !araRequest |=> alertOe)
		else $error("alert dropped early");
endmodule : alert_limit_enable_bank_monitor

bind alert_limit_enable_bank alert_limit_enable_bank_monitor alert_limit_enable_bank_monitor_i (
	.clk, .rst_n, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .regRvalid,
	.araRequest, .araAck, .araAddr, .alertOe
);

/* smbus_host_model.sv */
// host that answers a low alert line with an alert response request
`timescale 1ns/10ps
module smbus_host_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// alert line level and response delay
	input  wire logic       alertLine_n,
	input  wire logic [3:0] respDelay,
	// request to the device
	output logic            araRequest
);
	logic [3:0] waitCnt;
	always @(posedge clk) begin
		araRequest <= 1'b0;
		if (!rst_n || alertLine_n || araRequest) begin
			waitCnt <= 4'h0;
		end else if (waitCnt == respDelay) begin
			araRequest <= 1'b1;
		end else begin
			waitCnt <= waitCnt + 4'h1;
		end
	end
endmodule : smbus_host_model

/* alert_limit_enable_bank_bench.sv */
// self-checking bench for the alert bank
`timescale 1ns/10ps
module alert_limit_enable_bank_bench
	import alert_pkg::*;
;
	logic                       clk, rst_n, regWrite, regRead, regRvalid;
	logic                       araRequest, araAck, alertOut, alertOe;
	logic [ADDR_W-1:0]          regAddr;
	logic [REG_W-1:0]           regWdata, regRdata;
	logic [6:0]                 araAddr;
	logic [LIMIT_N*REG_W-1:0]   measures;
	logic [4:0]                 phase;
	logic [2:0]                 limitFlags;
	int                         ackCount;
	logic [3:0]                 respDelay;
	int                         n_mismatch, cmp_count;
	// pulled-up open-drain line
	wire logic alertLine_n = alertOe ? alertOut : 1'b1;
	alert_limit_enable_bank alert_limit_enable_bank_i (
		.clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
		.araRequest(araRequest), .araAck(araAck), .araAddr(araAddr), .measures(measures),
		.measValid(limitFlags[2]), .qcountLow(limitFlags[1]), .qcountHigh(limitFlags[0]),
		.equalizeActive(phase[4]),
		.absorbActive(phase[3]), .chargerSuspended(phase[2]), .prechargeActive(phase[1]),
		.constantPhase(phase[0]), .alertOut(alertOut), .alertOe(alertOe)
	);
	smbus_host_model smbus_host_model_i (
		.clk(clk), .rst_n(rst_n), .alertLine_n(alertLine_n), .respDelay(respDelay),
		.araRequest(araRequest)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// alert claims that carry the expected own address
	always @(posedge clk) begin
		if (!rst_n) ackCount <= 0;
		else if (araAck === 1'b1 && araAddr === DEV_ADDR_DEFAULT) ackCount <= ackCount + 1;
	end
	task automatic stop_test();
		if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		check("read data", {regRvalid, regRdata}, {1'b1, e});
		@(posedge clk);
	endtask : rd
	// bounded wait for the alert line level
	task automatic waitLine(input logic lvl);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (alertLine_n !== lvl && k < 20);
		check("alert line", {16'h0, alertLine_n}, {16'h0, lvl});
		if (alertLine_n !== lvl) stop_test();
		@(posedge clk);
	endtask : waitLine
	task automatic rwRegs();
		for (int a = 1; a <= 14; a++) rd(8'(a), REG_RESET);
		wr(ADDR_LIMIT_EN, 16'hbfff);
		rd(ADDR_LIMIT_EN, 16'hbfff);
		wr(ADDR_LIMIT_EN, 16'h0000);
		wr(ADDR_STATE_EN, 16'h07c0);
		rd(ADDR_STATE_EN, 16'h07c0);
		wr(ADDR_STATE_EN, 16'h0000);
		wr(8'h20, 16'hffff);
		rd(8'h20, 16'h0000);
		for (int a = 1; a <= 12; a++) begin
			wr(8'(a), 16'h8001 ^ 16'(a << 8));
			rd(8'(a), 16'h8001 ^ 16'(a << 8));
		end
	endtask : rwRegs
	task automatic limitCase(input int idx, input int en, input logic [15:0] lim,
		input logic [15:0] ok, input logic [15:0] bad);
		wr(ADDR_LIMIT_FIRST + 8'(idx), lim);
		measures[idx*16 +: 16] <= ok;
		wr(ADDR_LIMIT_EN, 16'h0001 << en);
		repeat (3) @(posedge clk);
		#1;
		check("quiet line", {16'h0, alertLine_n}, 17'h00001);
		@(posedge clk);
		measures[idx*16 +: 16] <= bad;
		waitLine(1'b0);
		measures[idx*16 +: 16] <= ok;
		waitLine(1'b1);
		rd(ADDR_LIMIT_STAT, 16'h0001 << en);
		wr(ADDR_LIMIT_STAT, 16'h0000);
		rd(ADDR_LIMIT_STAT, 16'h0000);
		wr(ADDR_LIMIT_EN, 16'h0000);
	endtask : limitCase
	task automatic flagCase(input int en, input logic [2:0] fl);
		wr(ADDR_LIMIT_EN, 16'h0001 << en);
		limitFlags <= fl;
		waitLine(1'b0);
		limitFlags <= 3'h0;
		waitLine(1'b1);
		rd(ADDR_LIMIT_STAT, 16'h0001 << en);
		wr(ADDR_LIMIT_STAT, 16'h0000);
		wr(ADDR_LIMIT_EN, 16'h0000);
	endtask : flagCase
	task automatic phaseAlerts();
		phase <= 5'h04;
		repeat (3) @(posedge clk);
		#1;
		check("masked line", {16'h0, alertLine_n}, 17'h00001);
		@(posedge clk);
		phase <= 5'h00;
		for (int b = 6; b <= 10; b++) begin
			wr(ADDR_STATE_EN, 16'h0001 << b);
			phase <= 5'h01 << (b - 6);
			waitLine(1'b0);
			rd(ADDR_STATE_STAT, 16'h0001 << b);
			waitLine(1'b1);
			phase <= 5'h00;
			wr(ADDR_STATE_STAT, 16'h0000);
		end
		rd(ADDR_STATE_STAT, 16'h0000);
	endtask : phaseAlerts
	initial begin
		rst_n = 1'b0;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 16'h0000;
		measures = '0;
		phase = 5'h00;
		limitFlags = 3'h0;
		respDelay = 4'h8;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rwRegs();
		limitCase(LIM_VBAT_LO, EN_VBAT_LO, 16'hff00, 16'h0100, 16'hfe00);
		limitCase(LIM_COLD, EN_COLD, 16'h0100, 16'hff00, 16'h0200);
		limitCase(LIM_HOT, EN_HOT, 16'h0010, 16'h0010, 16'h000f);
		limitCase(LIM_DIE_HI, EN_DIE_HI, 16'h1000, 16'h1000, 16'h1001);
		flagCase(EN_MEAS_VALID, 3'h4);
		flagCase(EN_QCOUNT_LO, 3'h2);
		flagCase(EN_QCOUNT_HI, 3'h1);
		respDelay <= 4'h0;
		phaseAlerts();
		check("alert claims", 17'(ackCount), 17'h0000c);
		stop_test();
	end
endmodule : alert_limit_enable_bank_bench
